// ### core/dld_map.vh
// dc load diagnostic sequencer constants
// assumes a 25 MHz core clock; included by design files
`ifndef DLD_MAP_VH
`define DLD_MAP_VH
`define DLD_CLK_HZ           25000000
`define DLD_RETEST_MS        750
`define DLD_RETEST_CYC       ((`DLD_CLK_HZ / 1000) * `DLD_RETEST_MS)
`define DLD_REQ_HOLD         2'b00
`define DLD_REQ_HIZ          2'b01
`define DLD_REQ_MUTE         2'b10
`define DLD_REQ_DIAG         2'b11
`define DLD_REQ_PLAY_BIT     0
`define DLD_ST_HIZ           3'h0
`define DLD_ST_DIAG_DONE     3'h1
`define DLD_ST_MUTE          3'h2
`define DLD_ST_PLAY          3'h3
`define DLD_ST_DIAG          3'h4
`define DLD_ST_RETRY         3'h5
`define DLD_F_GND            0
`define DLD_F_SUP            1
`define DLD_F_SHORT          2
`define DLD_F_OPEN           3
`define DLD_F_LINE           4
`define DLD_FW               5
`endif

// ### core/dld_timer.v
// retest interval timer: counts down and pulses when it expires
// assumes core clock; start reloads
`timescale 1ns/1ns
`include "dld_map.vh"
module dld_timer #(
  parameter integer CYCLES = `DLD_RETEST_CYC
) (
  input  wire core_clk,
  input  wire rst,
  input  wire start,
  input  wire stop,
  output reg  expire
);
  reg [31:0] count;
  reg        run;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count  <= 32'h0;
      run    <= 1'b0;
      expire <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (stop) begin
        run <= 1'b0;
      end else if (start) begin
        run   <= 1'b1;
        count <= CYCLES - 1;
      end else if (run) begin
        if (count == 32'h0) begin
          run    <= 1'b0;
          expire <= 1'b1;
        end else begin
          count <= count - 32'h1;
        end
      end
    end
  end
endmodule // dld_timer

// ### core/dld_channel.v
// one channel diagnostic sequencer: decides test results and channel state
// assumes analog comparator levels are synchronous inputs
`timescale 1ns/1ns
`include "dld_map.vh"
module dld_channel #(
  parameter integer RETEST_CYCLES = `DLD_RETEST_CYC,
  parameter integer TEST_CYCLES   = 16
) (
  input  wire                core_clk,
  input  wire                rst,
  input  wire                auto_start,
  input  wire [1:0]          state_req,
  input  wire                state_req_wr,
  input  wire                skip_diag_on_unmute,
  input  wire                diag_enable,
  input  wire                line_out_en,
  input  wire                cmp_gnd_low,
  input  wire                cmp_sup_low,
  input  wire                cmp_load_below_min,
  input  wire                cmp_load_above_max,
  input  wire                cmp_line_present,
  output reg  [2:0]          channel_state_code,
  output reg                 diag_passed_flag,
  output reg  [`DLD_FW-1:0]  fault_report,
  output wire                diag_active
);
  localparam [4:0] S_IDLE = 5'b00001;
  localparam [4:0] S_TEST = 5'b00010;
  localparam [4:0] S_LINE = 5'b00100;
  localparam [4:0] S_WAIT = 5'b01000;
  localparam [4:0] S_DONE = 5'b10000;
  reg [4:0]          state;
  reg [15:0]         tcnt;
  reg                manual;
  reg [1:0]          target;
  reg [`DLD_FW-1:0]  faults;
  wire               retry_go;
  assign diag_active = (state == S_TEST) || (state == S_LINE);
  dld_timer #(.CYCLES(RETEST_CYCLES)) u_retry (
    .core_clk (core_clk),
    .rst      (rst),
    .start    (state == S_DONE && faults[3:0] != 4'h0 && !manual),
    .stop     (!diag_enable),
    .expire   (retry_go)
  );
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state              <= S_IDLE;
      tcnt               <= 16'h0;
      manual             <= 1'b0;
      target             <= `DLD_REQ_HIZ;
      faults             <= {`DLD_FW{1'b0}};
      fault_report       <= {`DLD_FW{1'b0}};
      diag_passed_flag   <= 1'b0;
      channel_state_code <= `DLD_ST_HIZ;
    end else begin
      case (state)
        S_IDLE: begin
          tcnt   <= 16'h0;
          faults <= {`DLD_FW{1'b0}};
          if (auto_start) begin
            state              <= S_TEST;
            manual             <= 1'b0;
            target             <= `DLD_REQ_HIZ;
            channel_state_code <= `DLD_ST_DIAG;
          end else if (state_req_wr && state_req == `DLD_REQ_DIAG) begin
            state              <= S_TEST;
            manual             <= 1'b1;
            target             <= `DLD_REQ_HIZ;
            channel_state_code <= `DLD_ST_DIAG;
          end else if (state_req_wr && state_req == `DLD_REQ_HIZ) begin
            target             <= `DLD_REQ_HIZ;
            channel_state_code <= `DLD_ST_HIZ;
          end else if (state_req_wr && state_req == `DLD_REQ_MUTE) begin
            if (diag_passed_flag || skip_diag_on_unmute) begin
              channel_state_code <= `DLD_ST_MUTE;
            end else if (diag_enable) begin
              state              <= S_TEST;
              manual             <= 1'b0;
              target             <= `DLD_REQ_MUTE;
              channel_state_code <= `DLD_ST_DIAG;
            end
          end
          // retry pulse lasts one cycle, so it must win over any request
          if (retry_go && diag_enable) begin
            state              <= S_TEST;
            channel_state_code <= `DLD_ST_DIAG;
          end
        end
        S_TEST: begin
          tcnt <= tcnt + 16'h1;
          if (tcnt == TEST_CYCLES - 1) begin
            faults[`DLD_F_GND]   <= cmp_gnd_low;
            faults[`DLD_F_SUP]   <= cmp_sup_low;
            faults[`DLD_F_SHORT] <= cmp_load_below_min;
            faults[`DLD_F_OPEN]  <= cmp_load_above_max;
            tcnt <= 16'h0;
            state <= (cmp_load_above_max && line_out_en) ? S_LINE : S_DONE;
          end
        end
        S_LINE: begin
          tcnt <= tcnt + 16'h1;
          if (tcnt == TEST_CYCLES - 1) begin
            faults[`DLD_F_LINE] <= cmp_line_present;
            state <= S_DONE;
          end
        end
        S_DONE: begin
          fault_report <= faults;
          diag_passed_flag <= (faults[3:0] == 4'h0);
          if (manual)
            channel_state_code <= `DLD_ST_DIAG_DONE;
          else if (faults[3:0] == 4'h0 && target == `DLD_REQ_MUTE)
            channel_state_code <= `DLD_ST_MUTE;
          else
            channel_state_code <= `DLD_ST_HIZ;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // dld_channel

// ### core/dld_seq.v
// four-channel dc load diagnostic sequencer top
// assumes standby pin, state requests and comparator levels sync to core_clk
`timescale 1ns/1ns
`include "dld_map.vh"
module dld_seq #(
  parameter integer RETEST_CYCLES = `DLD_RETEST_CYC,
  parameter integer CHANNELS      = 4
) (
  input  wire                        core_clk,
  input  wire                        rst,
  input  wire                        standby_n,
  input  wire                        inhibit_auto_diag,
  input  wire                        skip_diag_on_unmute,
  input  wire                        diag_enable,
  input  wire [CHANNELS-1:0]         line_out_en,
  input  wire [2*CHANNELS-1:0]       channel_state_request,
  input  wire [CHANNELS-1:0]         state_req_wr,
  input  wire [CHANNELS-1:0]         cmp_gnd_low,
  input  wire [CHANNELS-1:0]         cmp_sup_low,
  input  wire [CHANNELS-1:0]         cmp_load_below_min,
  input  wire [CHANNELS-1:0]         cmp_load_above_max,
  input  wire [CHANNELS-1:0]         cmp_line_present,
  output wire [3*CHANNELS-1:0]       channel_state_code,
  output wire [CHANNELS-1:0]         diag_passed_flag,
  output wire [`DLD_FW*CHANNELS-1:0] fault_report,
  output wire [CHANNELS-1:0]         diag_active,
  output reg                         fault_n_out,
  output reg                         fault_n_oe
);
  reg  standby_q;
  reg  init_done;
  wire auto_start = standby_n & ~standby_q & init_done & ~inhibit_auto_diag;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      standby_q   <= 1'b1;
      init_done   <= 1'b0;
      fault_n_out <= 1'b0;
      fault_n_oe  <= 1'b1;
    end else begin
      standby_q   <= standby_n;
      init_done   <= 1'b1;
      fault_n_oe  <= 1'b0;
    end
  end
  genvar i;
  generate
    for (i = 0; i < CHANNELS; i = i + 1) begin : g_ch
      dld_channel #(.RETEST_CYCLES(RETEST_CYCLES)) u_ch (
        .core_clk            (core_clk),
        .rst                 (rst),
        .auto_start          (auto_start),
        .state_req           (channel_state_request[2*i+1:2*i]),
        .state_req_wr        (state_req_wr[i]),
        .skip_diag_on_unmute (skip_diag_on_unmute),
        .diag_enable         (diag_enable & standby_n),
        .line_out_en         (line_out_en[i]),
        .cmp_gnd_low         (cmp_gnd_low[i]),
        .cmp_sup_low         (cmp_sup_low[i]),
        .cmp_load_below_min  (cmp_load_below_min[i]),
        .cmp_load_above_max  (cmp_load_above_max[i]),
        .cmp_line_present    (cmp_line_present[i]),
        .channel_state_code  (channel_state_code[3*i+2:3*i]),
        .diag_passed_flag    (diag_passed_flag[i]),
        .fault_report        (fault_report[`DLD_FW*i+`DLD_FW-1:`DLD_FW*i]),
        .diag_active         (diag_active[i])
      );
    end
  endgenerate
endmodule // dld_seq

// ### verification/dld_seq_chk.sv
// port checker for the dc load diagnostic sequencer
// bound to every dld_seq instance; watches channel 0, the shared pins and diag_active of every channel
`timescale 1ns/1ns
module dld_seq_chk #(
  parameter integer CHANNELS = 4
) (
  input wire                 core_clk,
  input wire                 rst,
  input wire                 standby_n,
  input wire                 inhibit_auto_diag,
  input wire [CHANNELS-1:0]  state_req_wr,
  input wire [3*CHANNELS-1:0] channel_state_code,
  input wire [CHANNELS-1:0]  diag_passed_flag,
  input wire [5*CHANNELS-1:0] fault_report,
  input wire [CHANNELS-1:0]  diag_active,
  input wire                 fault_n_oe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  chk_fault_release: assert property (!$past(rst) |-> !fault_n_oe)
    else $error("fault pin still driven after reset");
  chk_flag_no_fault: assert property (diag_passed_flag[0] |-> fault_report[3:0] == 4'h0)
    else $error("passed flag set with a fault recorded");
  chk_mute_pass: assert property (channel_state_code[2:0] == 3'h2 |-> diag_passed_flag[0])
    else $error("channel muted without a passed diagnostic");
  chk_run_min: assert property ($rose(diag_active[0]) |-> diag_active[0] [*8])
    else $error("diagnostic run ended too early");
  chk_run_bound: assert property ($rose(diag_active[0]) |-> ##[16:40] !diag_active[0])
    else $error("diagnostic run did not finish");
  chk_active_code: assert property (diag_active[0] |-> channel_state_code[2:0] == 3'h4)
    else $error("running channel not reporting diag state");
  chk_inhibit_auto: assert property (
    inhibit_auto_diag && $rose(standby_n) && state_req_wr == '0 |=> diag_active == '0)
    else $error("auto run started while inhibited");
  chk_auto_all: assert property (
    !inhibit_auto_diag && $rose(standby_n) |-> ##[1:3] diag_active == {CHANNELS{1'b1}})
    else $error("auto run did not start on all channels");
  cover property ($rose(diag_passed_flag[0]));
  cover property (channel_state_code[2:0] == 3'h2);
  cover property ($rose(fault_report[3]));
endmodule // dld_seq_chk
bind dld_seq dld_seq_chk #(.CHANNELS(CHANNELS)) u_dld_seq_chk (
  .core_clk(core_clk), .rst(rst), .standby_n(standby_n),
  .inhibit_auto_diag(inhibit_auto_diag), .state_req_wr(state_req_wr),
  .channel_state_code(channel_state_code), .diag_passed_flag(diag_passed_flag),
  .fault_report(fault_report), .diag_active(diag_active), .fault_n_oe(fault_n_oe));

// ### verification/dld_load_model.sv
// speaker load model giving comparator levels for four channels
// kind per channel: 0 good, 1 ground, 2 supply, 3 shorted, 4 open, 5 line out
`timescale 1ns/1ns
module dld_load_model (
  input  wire [11:0] load_kind,
  output reg  [3:0]  cmp_gnd_low,
  output reg  [3:0]  cmp_sup_low,
  output reg  [3:0]  cmp_load_below_min,
  output reg  [3:0]  cmp_load_above_max,
  output reg  [3:0]  cmp_line_present
);
  integer i;
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      cmp_gnd_low[i]        = load_kind[3*i+:3] == 3'h1;
      cmp_sup_low[i]        = load_kind[3*i+:3] == 3'h2;
      cmp_load_below_min[i] = load_kind[3*i+:3] == 3'h3;
      cmp_load_above_max[i] = load_kind[3*i+:3] >= 3'h4;
      cmp_line_present[i]   = load_kind[3*i+:3] == 3'h5;
    end
  end
endmodule // dld_load_model

// ### verification/test_dld_seq.sv
// testbench for the dc load diagnostic sequencer
// drives requests 1 ns after core_clk rises; load model feeds comparators
`timescale 1ns/1ns
module test_dld_seq;
  reg         core_clk = 1'b0, rst = 1'b1, standby_n = 1'b0;
  reg         inhibit_auto_diag = 1'b1, diag_enable = 1'b1;
  reg  [3:0]  line_out_en = 4'hf, state_req_wr = 4'h0;
  reg  [7:0]  channel_state_request = 8'h00;
  reg  [11:0] load_kind = 12'h000;
  wire [3:0]  gnd, sup, shrt, opn, lp, diag_passed_flag, diag_active;
  wire [11:0] channel_state_code;
  wire [19:0] fault_report;
  wire        fault_n_oe, fault_n_out;
  integer     err_count = 0, tests_run = 0, k;
  reg  [4:0]  exp_rep;
  always #20 core_clk = ~core_clk;
  dld_seq #(.RETEST_CYCLES(100), .CHANNELS(4)) u_dld_seq (.core_clk(core_clk), .rst(rst),
    .standby_n(standby_n), .inhibit_auto_diag(inhibit_auto_diag),
    .skip_diag_on_unmute(1'b0), .diag_enable(diag_enable), .line_out_en(line_out_en),
    .channel_state_request(channel_state_request), .state_req_wr(state_req_wr),
    .cmp_gnd_low(gnd), .cmp_sup_low(sup), .cmp_load_below_min(shrt),
    .cmp_load_above_max(opn), .cmp_line_present(lp), .channel_state_code(channel_state_code),
    .diag_passed_flag(diag_passed_flag), .fault_report(fault_report),
    .diag_active(diag_active), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe));
  dld_load_model u_dld_load_model (.load_kind(load_kind), .cmp_gnd_low(gnd),
    .cmp_sup_low(sup), .cmp_load_below_min(shrt), .cmp_load_above_max(opn),
    .cmp_line_present(lp));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      if (err_count == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task do_reset;
    begin
      rst = 1'b1;
      repeat (20) @(posedge core_clk);
      #1 check({fault_n_oe, fault_n_out}, 2'b10);
      rst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1 check(fault_n_oe, 1'b0);
    end
  endtask
  task req(input [1:0] ch, input [1:0] code);
    begin
      @(posedge core_clk);
      #1 channel_state_request[2*ch+:2] = code;
      state_req_wr[ch] = 1'b1;
      @(posedge core_clk);
      #1 state_req_wr = 4'h0;
    end
  endtask
  task wait_code(input [1:0] ch, input [2:0] code, input integer n);
    integer i;
    begin
      for (i = 0; i < n && channel_state_code[3*ch+:3] !== code; i = i + 1) begin
        @(posedge core_clk);
        #1;
      end
      check(channel_state_code[3*ch+:3], code);
    end
  endtask
  initial begin
    do_reset;
    standby_n = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 check(diag_active, 4'h0);
    for (k = 5; k >= 0; k = k - 1) begin
      load_kind[3*(k%4)+:3] = k;
      req(k % 4, 2'b01);
      req(k % 4, 2'b11);
      wait_code(k % 4, 3'h1, 60);
      exp_rep = (k == 5) ? 5'h18 : (k == 0) ? 5'h00 : 5'h01 << (k - 1);
      check(fault_report[5*(k%4)+:5], exp_rep);
      check(diag_passed_flag[k%4], k == 0);
    end
    load_kind[5:3] = 3'h0;
    req(1, 2'b10);
    wait_code(1, 3'h4, 3);
    wait_code(1, 3'h2, 60);
    req(0, 2'b10);
    wait_code(0, 3'h2, 4);
    diag_enable = 1'b0;
    req(2, 2'b10);
    repeat (40) @(posedge core_clk);
    #1 check(channel_state_code[8:6], 3'h1);
    check(diag_active[2], 1'b0);
    standby_n = 1'b0;
    inhibit_auto_diag = 1'b0;
    diag_enable = 1'b1;
    load_kind = 12'h100;
    do_reset;
    standby_n = 1'b1;
    repeat (60) @(posedge core_clk);
    #1 check(diag_passed_flag, 4'hb);
    check(fault_report[14:10], 5'h08);
    load_kind = 12'h000;
    for (k = 0; k < 300 && diag_passed_flag[2] !== 1'b1; k = k + 1) begin
      @(posedge core_clk);
      #1;
    end
    check(diag_passed_flag, 4'hf);
    req(3, 2'b10);
    wait_code(3, 3'h2, 4);
    results;
  end
  initial begin
    #(40 * 3000);
    err_count = err_count + 1;
    results;
  end
endmodule // test_dld_seq
